// *** mii_rmii_mac_interface.v ***
// PHY-side MII/RMII MAC interface with receive elasticity FIFO.
//
// Contract
// - PHY sources TX clock; MAC launches on rise.
// - PHY drives RX clock, data and RX_DV.
// - PHY raises RX_ER on receive errors.
// - Mode chosen by strap, not register.
// - RMII: one clock, 2-bit paths, 10/100.
// - CRS_DV asserts asynchronously on carrier detect.
// - CRS_DV drops only on first di-bit.
// - Leftover bits: CRS_DV toggles per di-bit.
// - False carrier keeps CRS_DV high throughout.
// - RXD reads 00 until decoding established.
// - RMII signals timed by REF_CLK, except CRS_DV assertion.
// - Receive path uses an elasticity buffer.
// - RX_ER still driven in RMII mode.
// - Pins multiplexed by mode, COL carries CRS_DV.
// - CRS follows TX and RX in half duplex.
// - Half duplex collision on RX during TX.
`timescale 1ns/1ps
`default_nettype none
`include "mac_if_defs.vh"

module rx_elastic_fifo #(
  parameter WIDTH = `RX_FIFO_WIDTH,
  parameter DEPTH = `RX_FIFO_DEPTH
) (
  input  wire             clk_i,      // System clock.
  input  wire             rst_n_i,    // Synchronous reset, active low.
  input  wire             in_valid_i, // Write request.
  output wire             in_ready_o, // Space available.
  input  wire [WIDTH-1:0] in_data_i,  // Write data.
  output wire             out_valid_o,// Data available.
  input  wire             out_ready_i,// Read acknowledge.
  output wire [WIDTH-1:0] out_data_o  // Read data.
);
  function integer clog2;
    input integer v;
    integer       t;
    begin
      t = v - 1;
      clog2 = 0;
      while (t > 0) begin
        t = t >> 1;
        clog2 = clog2 + 1;
      end
    end
  endfunction

  localparam AW = clog2(DEPTH);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  reg             full_r;
  reg             empty_r;
  reg             ready_r;
  wire            push;
  wire            pop;
  reg [AW:0]      count_nxt;

  assign push        = in_valid_i & ~full_r;
  assign pop         = out_ready_i & ~empty_r;
  assign in_ready_o  = ready_r;
  assign out_valid_o = ~empty_r;
  assign out_data_o  = mem_r[rd_ptr_r];

  always @* begin
    count_nxt = count_r;
    if (push & ~pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop & ~push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Full and empty are registered so the write-side ready leaves a flop.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
      full_r   <= 1'b0;
      empty_r  <= 1'b1;
      ready_r  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      full_r  <= (count_nxt == DEPTH);
      ready_r <= (count_nxt != DEPTH);
      empty_r <= (count_nxt == {(AW+1){1'b0}});
    end
  end
endmodule // rx_elastic_fifo

module mii_rmii_mac_interface #(
  parameter FIFO_DEPTH = `RX_FIFO_DEPTH
) (
  input  wire       clk_i,                        // System clock, 200 MHz.
  input  wire       rst_n_i,                      // Synchronous reset, active low.
  input  wire       mac_interface_select_strap_i, // Strap pin: 1 selects RMII.
  input  wire       speed_100_i,                  // 1 = 100 Mbps, 0 = 10 Mbps.
  input  wire       full_duplex_i,                // 1 = full duplex.
  input  wire       ref_clk_i,                    // RMII reference clock pin.
  input  wire [3:0] txd_i,                        // Transmit data pins.
  input  wire       tx_en_i,                      // Transmit enable pin.
  input  wire       tx_er_i,                      // Transmit error pin (MII).
  output wire       mii_tx_clk_o,                 // MII transmit clock.
  output wire       mii_rx_clk_o,                 // MII receive clock.
  output reg  [3:0] rxd_o,                        // Receive data pins.
  output reg        rx_dv_o,                      // MII receive data valid.
  output reg        rx_er_o,                      // Receive error.
  output reg        crs_o,                        // MII carrier sense.
  output reg        col_crs_dv_o,                 // COL in MII, CRS_DV in RMII.
  output reg        rmii_mode_o,                  // Latched interface mode.
  input  wire       line_rx_carrier_i,            // Carrier detected on line.
  input  wire       line_rx_valid_i,              // Decoded nibble strobe.
  input  wire [3:0] line_rx_data_i,               // Decoded nibble.
  input  wire       line_rx_err_i,                // Nibble decode error.
  output wire       line_rx_ready_o,              // Receive buffer has space.
  output reg        line_tx_valid_o,              // Transmit nibble strobe.
  output reg  [3:0] line_tx_data_o,               // Transmit nibble.
  output reg        line_tx_err_o                 // Transmit nibble error.
);
  localparam integer HALF_100_W = (`MII_PER_100_NS / 2) / `CLK_PER_NS;
  localparam integer HALF_10_W  = (`MII_PER_10_NS / 2) / `CLK_PER_NS;
  localparam integer REP_LAST_W = `RMII_REPEAT_10 - 1;
  localparam [5:0]   HALF_100   = HALF_100_W[5:0];
  localparam [5:0]   HALF_10    = HALF_10_W[5:0];
  localparam [3:0]   REP_LAST   = REP_LAST_W[3:0];

  // Pin synchronisers; the first stage feeds only the second.
  reg       strap_s1_r;
  reg       strap_s2_r;
  reg       ref_s1_r;
  reg       ref_s2_r;
  reg       ref_s3_r;
  reg [3:0] txd_s1_r;
  reg [3:0] txd_s2_r;
  reg       tx_en_s1_r;
  reg       tx_en_s2_r;
  reg       tx_er_s1_r;
  reg       tx_er_s2_r;

  always @(posedge clk_i) begin
    strap_s1_r <= mac_interface_select_strap_i;
    strap_s2_r <= strap_s1_r;
    ref_s1_r   <= ref_clk_i;
    ref_s2_r   <= ref_s1_r;
    ref_s3_r   <= ref_s2_r;
    txd_s1_r   <= txd_i;
    txd_s2_r   <= txd_s1_r;
    tx_en_s1_r <= tx_en_i;
    tx_en_s2_r <= tx_en_s1_r;
    tx_er_s1_r <= tx_er_i;
    tx_er_s2_r <= tx_er_s1_r;
  end

  // The mode is caught once, on the first edge after reset release, so a
  // strap pin reused as RXD2 later cannot flip the interface mid-traffic.
  reg strap_done_r;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      strap_done_r <= 1'b0;
      rmii_mode_o  <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      rmii_mode_o  <= strap_s2_r;
    end
  end

  // MII clock divider shared by transmit and receive clocks.
  reg  [5:0] div_cnt_r;
  reg        mii_clk_r;
  wire [5:0] half_cyc = speed_100_i ? HALF_100 : HALF_10;
  wire       div_wrap = (div_cnt_r >= half_cyc - 6'h01);
  wire       mii_fall = div_wrap & mii_clk_r & ~rmii_mode_o;

  always @(posedge clk_i) begin
    if (!rst_n_i || rmii_mode_o) begin
      div_cnt_r <= 6'h00;
      mii_clk_r <= 1'b0;
    end else if (div_wrap) begin
      div_cnt_r <= 6'h00;
      mii_clk_r <= ~mii_clk_r;
    end else begin
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  assign mii_tx_clk_o = mii_clk_r;
  assign mii_rx_clk_o = mii_clk_r;

  // Reference clock edges and di-bit pacing; at 10 Mbps a di-bit spans
  // ten reference cycles and only the first of them is acted on.
  wire      ref_rise = ref_s2_r & ~ref_s3_r & rmii_mode_o;
  reg [3:0] rep_cnt_r;
  wire      dibit_step = ref_rise & (rep_cnt_r == 4'h0);

  always @(posedge clk_i) begin
    if (!rst_n_i || speed_100_i) begin
      rep_cnt_r <= 4'h0;
    end else if (ref_rise) begin
      rep_cnt_r <= (rep_cnt_r == REP_LAST) ? 4'h0 : rep_cnt_r + 4'h1;
    end
  end

  // Receive elasticity buffer between line decoder and MAC pins.
  wire                      fifo_valid;
  wire [`RX_FIFO_WIDTH-1:0] fifo_data;
  reg                       dibit_phase_r;
  wire                      fifo_pop = fifo_valid &
                                       (rmii_mode_o ? (dibit_step & (dibit_phase_r == `DIBIT_FIRST)) : mii_fall);

  rx_elastic_fifo #(
    .WIDTH (`RX_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (line_rx_valid_i),
    .in_ready_o  (line_rx_ready_o),
    .in_data_i   ({line_rx_err_i, line_rx_data_i}),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  wire [3:0] fifo_nib = fifo_data[`RXW_NIB_HI:0];
  wire       fifo_err = fifo_data[`RXW_ERR_BIT];

  // Transmit capture: MII on the divided clock, RMII di-bits low first.
  // The upper data pins are not looked at in RMII, the MAC grounds them.
  reg [1:0] tx_lo_r;
  reg       tx_half_r;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      line_tx_valid_o <= 1'b0;
      line_tx_data_o  <= 4'h0;
      line_tx_err_o   <= 1'b0;
      tx_lo_r         <= 2'h0;
      tx_half_r       <= 1'b0;
    end else begin
      line_tx_valid_o <= 1'b0;
      if (mii_fall && tx_en_s2_r) begin
        line_tx_valid_o <= 1'b1;
        line_tx_data_o  <= txd_s2_r;
        line_tx_err_o   <= tx_er_s2_r;
      end else if (dibit_step) begin
        if (!tx_en_s2_r) begin
          tx_half_r <= 1'b0;
        end else if (!tx_half_r) begin
          tx_lo_r   <= txd_s2_r[1:0];
          tx_half_r <= 1'b1;
        end else begin
          line_tx_valid_o <= 1'b1;
          line_tx_data_o  <= {txd_s2_r[1:0], tx_lo_r};
          line_tx_err_o   <= 1'b0;
          tx_half_r       <= 1'b0;
        end
      end
    end
  end

  // Receive presentation and pin multiplexing.
  reg [1:0] rx_hi_r;
  reg       crs_dv_r;
  wire      tx_active = tx_en_s2_r & ~full_duplex_i;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rxd_o         <= 4'h0;
      rx_dv_o       <= 1'b0;
      rx_er_o       <= 1'b0;
      crs_o         <= 1'b0;
      col_crs_dv_o  <= 1'b0;
      rx_hi_r       <= 2'h0;
      crs_dv_r      <= 1'b0;
      dibit_phase_r <= `DIBIT_FIRST;
    end else if (!rmii_mode_o) begin
      crs_o        <= line_rx_carrier_i | tx_active;
      col_crs_dv_o <= line_rx_carrier_i & tx_active;
      if (mii_fall) begin
        rx_dv_o <= fifo_valid;
        rxd_o   <= fifo_valid ? fifo_nib : 4'h0;
        rx_er_o <= fifo_valid & fifo_err;
      end
    end else begin
      // MII-only pins stay quiet in RMII mode.
      crs_o   <= 1'b0;
      rx_dv_o <= 1'b0;
      rxd_o[3:2] <= 2'h0;
      if (dibit_step && dibit_phase_r == `DIBIT_FIRST) begin
        // A fresh carrier drop is seen here only, on a nibble boundary.
        crs_dv_r     <= line_rx_carrier_i;
        col_crs_dv_o <= line_rx_carrier_i;
        if (fifo_valid) begin
          rxd_o[1:0]    <= fifo_nib[1:0];
          rx_hi_r       <= fifo_nib[3:2];
          rx_er_o       <= fifo_err;
          dibit_phase_r <= `DIBIT_SECOND;
        end else begin
          rxd_o[1:0] <= 2'h0;
          rx_er_o    <= 1'b0;
        end
      end else if (dibit_step) begin
        // Bits of this nibble remain, so CRS_DV is high on its second half.
        rxd_o[1:0]    <= rx_hi_r;
        crs_dv_r      <= 1'b1;
        col_crs_dv_o  <= 1'b1;
        dibit_phase_r <= `DIBIT_FIRST;
      end else if (line_rx_carrier_i && !crs_dv_r) begin
        // Carrier raises CRS_DV without waiting for a reference edge.
        crs_dv_r     <= 1'b1;
        col_crs_dv_o <= 1'b1;
      end
    end
  end
endmodule // mii_rmii_mac_interface
`default_nettype wire

// *** mac_if_defs.vh ***
// Shared constants for the PHY-side MII/RMII MAC interface.
`ifndef MAC_IF_DEFS_VH
`define MAC_IF_DEFS_VH

// System clock period in ns (200 MHz).
`define CLK_PER_NS          5
// MII clock periods in ns at 100 Mbps and 10 Mbps.
`define MII_PER_100_NS      40
`define MII_PER_10_NS       400
// Reference clock cycles each di-bit is held at 10 Mbps.
`define RMII_REPEAT_10      10
// Receive elasticity buffer: nibble plus error flag, sixteen entries.
`define RX_FIFO_WIDTH       5
`define RX_FIFO_DEPTH       16
// Field positions inside a buffered receive word.
`define RXW_ERR_BIT         4
`define RXW_NIB_HI          3
// Di-bit phase within a nibble.
`define DIBIT_FIRST         1'b0
`define DIBIT_SECOND        1'b1

`endif

// *** mac_if_assertions.sv ***
// Port checker for the MII/RMII MAC interface.
`timescale 1ns/1ps
`default_nettype none
module mac_if_assertions (
  input wire logic       clk_i,             // Clock.
  input wire logic       rst_n_i,           // Reset, low.
  input wire logic       full_duplex_i,     // Duplex.
  input wire logic       line_rx_carrier_i, // Carrier.
  input wire logic       mii_tx_clk_o,      // TX clock.
  input wire logic       mii_rx_clk_o,      // RX clock.
  input wire logic [3:0] rxd_o,             // RX data.
  input wire logic       rx_dv_o,           // RX valid.
  input wire logic       crs_o,             // Carrier sense.
  input wire logic       col_crs_dv_o,      // COL or CRS_DV.
  input wire logic       rmii_mode_o,       // Mode.
  input wire logic       line_tx_valid_o,   // TX strobe.
  input wire logic       line_tx_err_o      // TX error.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_clk_shared: assert property (mii_tx_clk_o == mii_rx_clk_o)
    else $error("tx and rx clocks differ");
  a_rmii_upper_zero: assert property (rmii_mode_o |-> rxd_o[3:2] == 2'h0)
    else $error("upper rxd set in rmii");
  a_rmii_mii_idle: assert property (rmii_mode_o |-> !rx_dv_o && !crs_o && !mii_tx_clk_o)
    else $error("mii pin active in rmii");
  a_rmii_no_txerr: assert property (rmii_mode_o |-> !line_tx_err_o)
    else $error("tx error in rmii");
  a_crs_dv_carrier: assert property (rmii_mode_o && $past(line_rx_carrier_i) |-> col_crs_dv_o)
    else $error("crs_dv low during carrier");
  a_rxd_on_fall: assert property (!rmii_mode_o && !$stable(rxd_o) |-> !mii_rx_clk_o)
    else $error("rxd moved while rx clock high");
  a_tx_pulse_one: assert property (line_tx_valid_o |=> !line_tx_valid_o)
    else $error("tx strobe longer than one cycle");
  a_col_full_off: assert property (!rmii_mode_o && $past(full_duplex_i) |-> !col_crs_dv_o)
    else $error("collision in full duplex");
  c_crs_dv_fall: cover property (rmii_mode_o && $fell(col_crs_dv_o));
  c_tx_err: cover property (line_tx_valid_o && line_tx_err_o);
  c_mii_rx: cover property (rx_dv_o && crs_o);
endmodule // mac_if_assertions
bind mii_rmii_mac_interface mac_if_assertions mac_if_assertions_inst (.*);
`default_nettype wire

// *** mac_model.sv ***
// Behavioural MAC that sends one four-nibble frame while asked.
`timescale 1ns/1ps
`default_nettype none
`include "mac_if_defs.vh"
module mac_model (
  input  wire logic       tx_clk_i,  // MII TX clock.
  input  wire logic       speed_100_i, // Rate, 1 = 100 Mbps.
  input  wire logic       ref_clk_i, // RMII clock.
  input  wire logic       rmii_i,    // Mode.
  input  wire logic       start_i,   // Send request.
  output logic      [3:0] txd_o,     // TX data.
  output logic            tx_en_o,   // TX enable.
  output logic            tx_er_o    // TX error.
);
  int         k = 0;
  int         rep = 0;
  logic       ph = 1'b0;
  logic [3:0] v;
  logic       go;
  wire logic  mclk;
  // One process owns every output, so the link clock is picked by mode.
  assign mclk = rmii_i ? ref_clk_i : tx_clk_i;
  assign v = 4'(k) ^ 4'ha;
  assign go = start_i && k < 4;
  initial begin
    txd_o = 4'h0;
    tx_en_o = 1'b0;
    tx_er_o = 1'b0;
  end
  // Idle data lines flip so that stale values are never mistaken for data.
  always @(posedge mclk) begin
    if (!rmii_i) begin
      tx_en_o <= go;
      tx_er_o <= go && k == 2;
      txd_o <= go ? v : ~txd_o;
      k <= start_i ? k + 1 : 0;
    end else begin
      rep <= (speed_100_i || rep == `RMII_REPEAT_10 - 1) ? 0 : rep + 1;
      if (speed_100_i || rep == 0) begin
        tx_en_o <= go;
        tx_er_o <= 1'b0;
        txd_o <= {2'b00, go ? (ph ? v[3:2] : v[1:0]) : ~txd_o[1:0]};
        ph <= go && !ph;
        k <= ph ? k + 1 : (start_i ? k : 0);
      end
    end
  end
endmodule // mac_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the MII/RMII MAC interface.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_i = 1'b0, rst_n_i = 1'b0, mac_interface_select_strap_i = 1'b0;
  logic       speed_100_i = 1'b1, full_duplex_i = 1'b0, ref_clk_i = 1'b0, start = 1'b0;
  logic       line_rx_carrier_i = 1'b0, line_rx_valid_i = 1'b0, line_rx_err_i = 1'b0;
  logic [3:0] line_rx_data_i = 4'h0, txd_i, rxd_o, line_tx_data_o;
  logic       tx_en_i, tx_er_i, mii_tx_clk_o, mii_rx_clk_o, rx_dv_o, rx_er_o, crs_o;
  logic       col_crs_dv_o, rmii_mode_o, line_rx_ready_o, line_tx_valid_o, line_tx_err_o;
  int         failures = 0, checks = 0, cyc = 0;
  logic [4:0] q[$];
  mii_rmii_mac_interface mii_rmii_mac_interface_inst (.*);
  mac_model mac_model_inst (.tx_clk_i(mii_tx_clk_o), .speed_100_i(speed_100_i), .ref_clk_i(ref_clk_i),
    .rmii_i(rmii_mode_o),
    .start_i(start), .txd_o(txd_i), .tx_en_o(tx_en_i), .tx_er_o(tx_er_i));
  initial forever #2.5 clk_i = ~clk_i;
  initial #7 forever #24 ref_clk_i = ~ref_clk_i;
  always @(posedge mii_rx_clk_o) if (rx_dv_o === 1'b1) q.push_back({rx_er_o, rxd_o});
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic reset(input logic strap);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    mac_interface_select_strap_i = strap;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("mode", strap, rmii_mode_o);
  endtask
  task automatic t_tx();
    int   n;
    logic cs, cl;
    n = 0;
    cs = 1'b0;
    cl = 1'b0;
    start = 1'b1;
    for (int i = 0; i < 2000 && n < 4; i++) begin
      @(negedge clk_i);
      cs |= crs_o & !line_rx_carrier_i;
      cl |= col_crs_dv_o;
      if (line_tx_valid_o === 1'b1) begin
        chk("tx nibble", 4'(n) ^ 4'ha, line_tx_data_o);
        chk("tx err", !rmii_mode_o && n == 2, line_tx_err_o);
        n++;
        line_rx_carrier_i = n >= 2;
      end
    end
    start = 1'b0;
    line_rx_carrier_i = 1'b0;
    chk("tx count", 4, n);
    chk("crs on tx", !rmii_mode_o, cs);
    chk("collision", 1, cl);
    repeat (200) @(negedge clk_i);
    $display("tx test done");
  endtask
  task automatic t_mii_rx();
    int   n;
    logic full;
    n = 0;
    full = 1'b0;
    full_duplex_i = 1'b1;
    line_rx_carrier_i = 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(negedge clk_i);
      full |= !line_rx_ready_o;
      line_rx_valid_i = line_rx_ready_o;
      line_rx_data_i = 4'(n);
      line_rx_err_i = n == 5;
      if (line_rx_ready_o === 1'b1) n++;
    end
    @(negedge clk_i);
    line_rx_valid_i = 1'b0;
    chk("crs on rx", 1, crs_o);
    repeat (400) @(negedge clk_i);
    line_rx_carrier_i = 1'b0;
    chk("fifo full", 1, full);
    chk("rx count", n, q.size());
    foreach (q[i]) chk("rx word", {i == 5, 4'(i)}, q[i]);
    $display("mii rx test done");
  endtask
  task automatic t_rmii_rx();
    logic [1:0] d[$];
    logic [1:0] e[4] = '{2'h2, 2'h1, 2'h1, 2'h2};
    logic       tog, p, er;
    tog = 1'b0;
    p = 1'b1;
    er = 1'b0;
    @(negedge clk_i);
    line_rx_carrier_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk("idle rxd", 3'h4, {col_crs_dv_o, rxd_o[1:0]});
    @(negedge clk_i);
    line_rx_valid_i = 1'b1;
    line_rx_data_i = 4'h6;
    @(negedge clk_i);
    line_rx_data_i = 4'h9;
    line_rx_err_i = 1'b1;
    @(negedge clk_i);
    line_rx_valid_i = 1'b0;
    line_rx_err_i = 1'b0;
    line_rx_carrier_i = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk_i);
      if (rxd_o[1:0] != 2'h0) d.push_back(rxd_o[1:0]);
      er |= rx_er_o;
      if (col_crs_dv_o && !p) tog = 1'b1;
      p = col_crs_dv_o;
    end
    chk("dibit count", 4, d.size());
    foreach (e[i]) chk("dibit", e[i], d[i]);
    chk("crs_dv toggle", 1, tog);
    chk("crs_dv end", 0, col_crs_dv_o);
    chk("rmii rx_er", 1, er);
    $display("rmii rx test done");
  endtask
  initial begin
    reset(1'b0);
    t_tx();
    speed_100_i = 1'b0;
    t_tx();
    speed_100_i = 1'b1;
    t_mii_rx();
    reset(1'b1);
    t_tx();
    speed_100_i = 1'b0;
    t_tx();
    speed_100_i = 1'b1;
    t_rmii_rx();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
